// [als_regs_pkg.sv]
// constants for the ambient-light and backlight parameter register bank
package als_regs_pkg;
    localparam logic [15:0] ADDR_AMB_HIGH = 16'h5a00;
    localparam logic [15:0] ADDR_AMB_LOW = 16'h5b00;
    localparam logic [15:0] ADDR_MED_HIGH = 16'h5c00;
    localparam logic [15:0] ADDR_MED_LOW = 16'h5d00;
    localparam logic [15:0] ADDR_FLOOR_WR = 16'h5e00;
    localparam logic [15:0] ADDR_FLOOR_RD = 16'h5f00;
    localparam logic [15:0] ADDR_COEFF_WR_HI = 16'h6500;
    localparam logic [15:0] ADDR_COEFF_WR_LO = 16'h6501;
    localparam logic [15:0] ADDR_COEFF_RD_HI = 16'h6600;
    localparam logic [15:0] ADDR_COEFF_RD_LO = 16'h6700;
    localparam logic [15:0] ADDR_BW_LOW = 16'h7000;
    localparam logic [15:0] ADDR_BLACK_X = 16'h7100;
    localparam logic [7:0] BYTE_ZERO = 8'h00;
    localparam logic [7:0] FLOOR_RESET = 8'h00;
    localparam logic [15:0] COEFF_RESET = 16'h8000;
    localparam logic [9:0] COORD_ZERO = 10'h000;
    localparam int COORD_TOP = 9;
    localparam int COORD_HIGH_LSB = 2;
endpackage : als_regs_pkg

// [als_pair_lock.sv]
// lock, refresh and release of one 16-bit sample read as two bytes
`timescale 1ns/1ps
`default_nettype none
module als_pair_lock (
    input wire logic clock, // system clock
    input wire logic rstn, // async reset, active low
    input wire logic [15:0] sample, // live sensor sample
    input wire logic enable, // ambient sensing enable
    input wire logic cmd_valid, // one-cycle command strobe
    input wire logic is_high, // command is the high-byte read
    input wire logic is_low, // command is the low-byte read
    output logic [7:0] rd_byte // byte returned for high or low read
);
    typedef enum logic [1:0] {
        LK_IDLE = 2'b00,
        LK_HIGH = 2'b01,
        LK_LOW = 2'b10
    } lock_t;

    lock_t state_r;
    logic [15:0] held_r;

    // on the first half the whole pair is captured; the second half reads held copy
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            state_r <= LK_IDLE;
            held_r <= {als_regs_pkg::BYTE_ZERO, als_regs_pkg::BYTE_ZERO};
        end else if (cmd_valid) begin
            case (state_r)
                LK_IDLE: begin
                    held_r <= sample;
                    state_r <= is_high ? LK_HIGH : (is_low ? LK_LOW : LK_IDLE);
                end
                LK_HIGH: begin
                    if (is_low) begin
                        state_r <= LK_IDLE;
                    end else if (is_high) begin
                        held_r <= sample;
                    end else begin
                        state_r <= LK_IDLE;
                    end
                end
                LK_LOW: begin
                    if (is_high) begin
                        state_r <= LK_IDLE;
                    end else if (is_low) begin
                        held_r <= sample;
                    end else begin
                        state_r <= LK_IDLE;
                    end
                end
                default: state_r <= LK_IDLE;
            endcase
        end
    end

    // byte answered in the same cycle as the command, from the pair it freezes
    logic [15:0] view;
    always_comb begin
        view = sample;
        if ((state_r == LK_HIGH && is_low) || (state_r == LK_LOW && is_high)) begin
            view = held_r;
        end
        if (!enable) begin
            rd_byte = als_regs_pkg::BYTE_ZERO;
        end else if (is_high) begin
            rd_byte = view[15:8];
        end else begin
            rd_byte = view[7:0];
        end
    end
endmodule : als_pair_lock
`default_nettype wire

// [als_param_regs.sv]
// command-addressed ambient-light, backlight floor, coefficient and colour registers
`timescale 1ns/1ps
`default_nettype none
module als_param_regs (
    input wire logic clock, // 100 MHz system clock
    input wire logic rstn, // async reset, active low
    input wire logic soft_reset, // one-cycle software reset pulse
    input wire logic cmd_valid, // one-cycle command strobe
    input wire logic cmd_write, // 1 write, 0 read
    input wire logic [15:0] cmd_addr, // 16-bit command address
    input wire logic [15:0] cmd_wdata, // write data, upper byte ignored
    input wire logic sense_enable, // ambient sensing enable from display control
    input wire logic [15:0] ambient_light_value, // filtered sensor sample
    input wire logic [15:0] median_ambient_value, // median-filtered sample
    input wire logic [9:0] black_x_rom, // black x from reprogrammable_rom
    input wire logic [9:0] black_y_rom, // black y from reprogrammable_rom
    input wire logic [9:0] white_x_coord_rom, // white x from reprogrammable_rom
    input wire logic [9:0] white_y_coord_rom, // white y from reprogrammable_rom
    input wire logic rom_programmed, // reprogrammable_rom holds valid data
    output logic [7:0] rd_data, // read byte, registered
    output logic rd_valid, // one-cycle read answer strobe
    output logic [7:0] backlight_floor_level, // content_adaptive_backlight floor
    output logic [15:0] light_comp_coeff // light compensation coefficient
);
    logic sync1_r;
    logic sync2_r;
    logic sense_en;
    logic rd_cmd;
    logic wr_cmd;
    logic hit_amb_high;
    logic hit_amb_low;
    logic hit_med_high;
    logic hit_med_low;
    logic hit_floor_wr;
    logic hit_floor_rd;
    logic hit_coeff_wr_hi;
    logic hit_coeff_wr_lo;
    logic hit_coeff_rd_hi;
    logic hit_coeff_rd_lo;
    logic hit_bw_low;
    logic hit_black_x;
    logic floor_we;
    logic coeff_hi_we;
    logic coeff_lo_we;
    logic sensor_hit;
    logic param_hit;
    logic colour_hit;
    logic [7:0] amb_byte;
    logic [7:0] med_byte;
    logic [7:0] sensor_byte;
    logic [7:0] param_byte;
    logic [7:0] colour_byte;
    logic [7:0] bw_low_byte;
    logic [7:0] black_x_byte;
    logic [7:0] floor_r;
    logic [7:0] coeff_hi_r;
    logic [7:0] coeff_lo_r;
    logic [9:0] bkx_r;
    logic [9:0] bky_r;
    logic [9:0] wx_r;
    logic [9:0] wy_r;
    logic reload_r;
    logic [7:0] rd_nxt;

    // sensing enable crosses from elsewhere; two flops before any use
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            sync1_r <= 1'b0;
            sync2_r <= 1'b0;
        end else begin
            sync1_r <= sense_enable;
            sync2_r <= sync1_r;
        end
    end
    assign sense_en = sync2_r;

    // no power-state gating: every command is accepted except in a soft_reset cycle
    assign rd_cmd = cmd_valid && !cmd_write && !soft_reset;
    assign wr_cmd = cmd_valid && cmd_write && !soft_reset;

    function automatic logic hit(input logic [15:0] a, input logic [15:0] b);
        hit = (a == b);
    endfunction : hit

    // an unprogrammed rom reads as zero rather than as whatever it powers up with
    function automatic logic [9:0] rom_or_zero(input logic valid, input logic [9:0] value);
        rom_or_zero = valid ? value : als_regs_pkg::COORD_ZERO;
    endfunction : rom_or_zero

    // every command address is compared once, here
    assign hit_amb_high = hit(cmd_addr, als_regs_pkg::ADDR_AMB_HIGH);
    assign hit_amb_low = hit(cmd_addr, als_regs_pkg::ADDR_AMB_LOW);
    assign hit_med_high = hit(cmd_addr, als_regs_pkg::ADDR_MED_HIGH);
    assign hit_med_low = hit(cmd_addr, als_regs_pkg::ADDR_MED_LOW);
    assign hit_floor_wr = hit(cmd_addr, als_regs_pkg::ADDR_FLOOR_WR);
    assign hit_floor_rd = hit(cmd_addr, als_regs_pkg::ADDR_FLOOR_RD);
    assign hit_coeff_wr_hi = hit(cmd_addr, als_regs_pkg::ADDR_COEFF_WR_HI);
    assign hit_coeff_wr_lo = hit(cmd_addr, als_regs_pkg::ADDR_COEFF_WR_LO);
    assign hit_coeff_rd_hi = hit(cmd_addr, als_regs_pkg::ADDR_COEFF_RD_HI);
    assign hit_coeff_rd_lo = hit(cmd_addr, als_regs_pkg::ADDR_COEFF_RD_LO);
    assign hit_bw_low = hit(cmd_addr, als_regs_pkg::ADDR_BW_LOW);
    assign hit_black_x = hit(cmd_addr, als_regs_pkg::ADDR_BLACK_X);

    assign floor_we = wr_cmd && hit_floor_wr;
    assign coeff_hi_we = wr_cmd && hit_coeff_wr_hi;
    assign coeff_lo_we = wr_cmd && hit_coeff_wr_lo;
    // read groups are one-hot by address, so the final mux needs no care for order
    assign sensor_hit = hit_amb_high || hit_amb_low || hit_med_high || hit_med_low;
    assign param_hit = hit_floor_rd || hit_coeff_rd_hi || hit_coeff_rd_lo;
    assign colour_hit = hit_bw_low || hit_black_x;

    als_pair_lock u_amb (
        .clock(clock),
        .rstn(rstn),
        .sample(ambient_light_value),
        .enable(sense_en),
        .cmd_valid(cmd_valid),
        .is_high(rd_cmd && hit_amb_high),
        .is_low(rd_cmd && hit_amb_low),
        .rd_byte(amb_byte)
    );

    als_pair_lock u_med (
        .clock(clock),
        .rstn(rstn),
        .sample(median_ambient_value),
        .enable(sense_en),
        .cmd_valid(cmd_valid),
        .is_high(rd_cmd && hit_med_high),
        .is_low(rd_cmd && hit_med_low),
        .rd_byte(med_byte)
    );

    // backlight floor, reset by hardware or software reset
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            floor_r <= als_regs_pkg::FLOOR_RESET;
        end else if (soft_reset) begin
            floor_r <= als_regs_pkg::FLOOR_RESET;
        end else if (floor_we) begin
            floor_r <= cmd_wdata[7:0];
        end
    end

    // coefficient: each parameter byte goes to its own half as it arrives, so a
    // host that stops after the high byte leaves the low half as it was
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            coeff_hi_r <= als_regs_pkg::COEFF_RESET[15:8];
        end else if (soft_reset) begin
            coeff_hi_r <= als_regs_pkg::COEFF_RESET[15:8];
        end else if (coeff_hi_we) begin
            coeff_hi_r <= cmd_wdata[7:0];
        end
    end

    // low half is written at its own address
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            coeff_lo_r <= als_regs_pkg::COEFF_RESET[7:0];
        end else if (soft_reset) begin
            coeff_lo_r <= als_regs_pkg::COEFF_RESET[7:0];
        end else if (coeff_lo_we) begin
            coeff_lo_r <= cmd_wdata[7:0];
        end
    end

    // colour coordinates reload one cycle after any reset, since the rom
    // value may not be a constant at the asynchronous edge
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            reload_r <= 1'b1;
        end else begin
            reload_r <= soft_reset;
        end
    end

    // each coordinate is reloaded on its own; all four follow the same rule
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            bkx_r <= als_regs_pkg::COORD_ZERO;
        end else if (reload_r) begin
            bkx_r <= rom_or_zero(rom_programmed, black_x_rom);
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            bky_r <= als_regs_pkg::COORD_ZERO;
        end else if (reload_r) begin
            bky_r <= rom_or_zero(rom_programmed, black_y_rom);
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            wx_r <= als_regs_pkg::COORD_ZERO;
        end else if (reload_r) begin
            wx_r <= rom_or_zero(rom_programmed, white_x_coord_rom);
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            wy_r <= als_regs_pkg::COORD_ZERO;
        end else if (reload_r) begin
            wy_r <= rom_or_zero(rom_programmed, white_y_coord_rom);
        end
    end

    // sensor reads come from the lock units, which already apply the enable
    always_comb begin
        sensor_byte = als_regs_pkg::BYTE_ZERO;
        if (hit_amb_high || hit_amb_low) begin
            sensor_byte = amb_byte;
        end else if (hit_med_high || hit_med_low) begin
            sensor_byte = med_byte;
        end
    end

    // parameter reads carry no lock, so the coefficient halves come in any order
    always_comb begin
        param_byte = als_regs_pkg::BYTE_ZERO;
        if (hit_floor_rd) begin
            param_byte = floor_r;
        end else if (hit_coeff_rd_hi) begin
            param_byte = coeff_hi_r;
        end else if (hit_coeff_rd_lo) begin
            param_byte = coeff_lo_r;
        end
    end

    // low bits of all four coordinates share one byte
    assign bw_low_byte = {bkx_r[1:0], bky_r[1:0], wx_r[1:0], wy_r[1:0]};
    assign black_x_byte = bkx_r[als_regs_pkg::COORD_TOP:als_regs_pkg::COORD_HIGH_LSB];

    // colour bytes are fixed after the reload; no lock applies to them
    always_comb begin
        colour_byte = als_regs_pkg::BYTE_ZERO;
        if (hit_bw_low) begin
            colour_byte = bw_low_byte;
        end else if (hit_black_x) begin
            colour_byte = black_x_byte;
        end
    end

    // unmapped reads answer zero
    always_comb begin
        rd_nxt = als_regs_pkg::BYTE_ZERO;
        if (sensor_hit) begin
            rd_nxt = sensor_byte;
        end else if (param_hit) begin
            rd_nxt = param_byte;
        end else if (colour_hit) begin
            rd_nxt = colour_byte;
        end
    end

    // the answer strobe is one cycle; the byte stands until the next read
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            rd_valid <= 1'b0;
        end else begin
            rd_valid <= rd_cmd;
        end
    end

    // a write leaves the last read byte in place
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            rd_data <= als_regs_pkg::BYTE_ZERO;
        end else if (rd_cmd) begin
            rd_data <= rd_nxt;
        end
    end

    assign backlight_floor_level = floor_r;
    assign light_comp_coeff = {coeff_hi_r, coeff_lo_r};
endmodule : als_param_regs
`default_nettype wire

// [als_param_regs_assertions.sv]
// port-level checks for the parameter register bank
`timescale 1ns/1ps
`default_nettype none
module als_param_regs_assertions (
    input wire logic clock, // clock
    input wire logic rstn, // reset, active low
    input wire logic soft_reset, // soft reset
    input wire logic cmd_valid, // strobe
    input wire logic cmd_write, // write
    input wire logic [15:0] cmd_addr, // address
    input wire logic [15:0] cmd_wdata, // data
    input wire logic sense_enable, // sensing on
    input wire logic [7:0] rd_data, // read byte
    input wire logic rd_valid, // answer
    input wire logic [7:0] backlight_floor_level, // floor
    input wire logic [15:0] light_comp_coeff // coeff
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstn);
    logic rt;
    logic wt;
    assign rt = cmd_valid && !cmd_write && !soft_reset;
    assign wt = cmd_valid && cmd_write && !soft_reset;
    property p_answer; rt |=> rd_valid; endproperty
    a_answer: assert property (p_answer) else $error("read not answered");
    property p_spur; rd_valid |-> $past(rt); endproperty
    a_spur: assert property (p_spur) else $error("answer without read");
    property p_hold; !rt && !soft_reset |=> $stable(rd_data); endproperty
    a_hold: assert property (p_hold) else $error("read byte moved");
    property p_flw; wt && cmd_addr == als_regs_pkg::ADDR_FLOOR_WR
        |=> backlight_floor_level == $past(cmd_wdata[7:0]); endproperty
    a_flw: assert property (p_flw) else $error("floor not stored");
    property p_chi; wt && cmd_addr == als_regs_pkg::ADDR_COEFF_WR_HI
        |=> light_comp_coeff[15:8] == $past(cmd_wdata[7:0]); endproperty
    a_chi: assert property (p_chi) else $error("coeff high not stored");
    property p_clo; wt && cmd_addr == als_regs_pkg::ADDR_COEFF_WR_LO
        |=> light_comp_coeff[7:0] == $past(cmd_wdata[7:0]); endproperty
    a_clo: assert property (p_clo) else $error("coeff low not stored");
    property p_soft; soft_reset |=> light_comp_coeff == 16'h8000 && backlight_floor_level == 8'h00;
    endproperty
    a_soft: assert property (p_soft) else $error("soft reset defaults wrong");
    property p_flr; rt && cmd_addr == als_regs_pkg::ADDR_FLOOR_RD
        |=> rd_data == $past(backlight_floor_level); endproperty
    a_flr: assert property (p_flr) else $error("floor read wrong");
    property p_crd; rt && cmd_addr == als_regs_pkg::ADDR_COEFF_RD_LO
        |=> rd_data == $past(light_comp_coeff[7:0]); endproperty
    a_crd: assert property (p_crd) else $error("coeff read wrong");
    // four cycles covers the enable synchroniser
    property p_off; !sense_enable [*4] ##0 (rt && cmd_addr[15:12] == 4'h5 && cmd_addr[11:8] inside
        {4'ha, 4'hb, 4'hc, 4'hd}) |=> rd_data == 8'h00; endproperty
    a_off: assert property (p_off) else $error("sensor byte not zero");
endmodule : als_param_regs_assertions
`default_nettype wire

// [host_model.sv]
// host that issues one command at a time and collects the answer
`timescale 1ns/1ps
`default_nettype none
module host_model (
    input wire logic clock, // clock
    input wire logic [7:0] rd_data, // read byte
    input wire logic rd_valid, // answer
    output logic cmd_valid, // strobe
    output logic cmd_write, // write
    output logic [15:0] cmd_addr, // address
    output logic [15:0] cmd_wdata // data
);
    initial begin
        cmd_valid = 1'b0;
        cmd_write = 1'b0;
        cmd_addr = 16'h0000;
        cmd_wdata = 16'h0000;
    end
    task automatic send(input logic w, input logic [15:0] a, input logic [15:0] d,
        output logic [7:0] q);
        int n;
        n = 0;
        q = 'x;
        @(posedge clock);
        cmd_valid <= 1'b1;
        cmd_write <= w;
        cmd_addr <= a;
        cmd_wdata <= d;
        @(posedge clock);
        cmd_valid <= 1'b0;
        // released lines show the inverse so stale values cannot match
        cmd_addr <= ~a;
        cmd_wdata <= ~d;
        while (!w && n < 8) begin
            @(posedge clock);
            n++;
            if (rd_valid === 1'b1) begin
                q = rd_data;
                n = 8;
            end
        end
    endtask : send
endmodule : host_model
`default_nettype wire

// [als_param_regs_tb.sv]
// self-checking bench for the parameter register bank
`timescale 1ns/1ps
`default_nettype none
bind als_param_regs als_param_regs_assertions chk (.clock(clock), .rstn(rstn),
    .soft_reset(soft_reset), .cmd_valid(cmd_valid), .cmd_write(cmd_write), .cmd_addr(cmd_addr),
    .cmd_wdata(cmd_wdata), .sense_enable(sense_enable), .rd_data(rd_data), .rd_valid(rd_valid),
    .backlight_floor_level(backlight_floor_level), .light_comp_coeff(light_comp_coeff));
module als_param_regs_tb;
    logic clock = 1'b0;
    logic rstn = 1'b0;
    logic soft_reset = 1'b0;
    logic sense_enable = 1'b1;
    logic rom_programmed = 1'b1;
    logic [15:0] amb = 16'h0000;
    logic [15:0] med = 16'h0000;
    logic [9:0] bx, by, wx, wy;
    logic cv, cw, rv;
    logic [15:0] ca, cd, coeff;
    logic [7:0] rdd, floor, q;
    logic [31:0] seed = 32'd36855;
    int mismatches = 0;
    int checked = 0;
    logic [15:0] hi_a [2] = '{als_regs_pkg::ADDR_AMB_HIGH, als_regs_pkg::ADDR_MED_HIGH};
    logic [15:0] lo_a [2] = '{als_regs_pkg::ADDR_AMB_LOW, als_regs_pkg::ADDR_MED_LOW};
    always #5 clock = ~clock;
    host_model host (.clock(clock), .rd_data(rdd), .rd_valid(rv), .cmd_valid(cv),
        .cmd_write(cw), .cmd_addr(ca), .cmd_wdata(cd));
    als_param_regs dut (.clock(clock), .rstn(rstn), .soft_reset(soft_reset), .cmd_valid(cv),
        .cmd_write(cw), .cmd_addr(ca), .cmd_wdata(cd), .sense_enable(sense_enable),
        .ambient_light_value(amb), .median_ambient_value(med), .black_x_rom(bx),
        .black_y_rom(by), .white_x_coord_rom(wx), .white_y_coord_rom(wy),
        .rom_programmed(rom_programmed), .rd_data(rdd), .rd_valid(rv),
        .backlight_floor_level(floor), .light_comp_coeff(coeff));
    function automatic logic [15:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[15:0];
    endfunction : rnd
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic rd(input logic [15:0] a);
        host.send(1'b0, a, rnd(), q);
    endtask : rd
    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        host.send(1'b1, a, d, q);
        // the write lands at the edge that takes it; outputs are looked at one edge later
        @(posedge clock);
    endtask : wr
    task automatic put(input int c, input logic [15:0] v);
        if (c == 0) amb <= v;
        else med <= v;
    endtask : put
    task automatic pair(input int c);
        logic [15:0] s0, s1, s2;
        s0 = rnd();
        s1 = rnd();
        s2 = rnd();
        put(c, s0); rd(lo_a[c]); check(q, s0[7:0]);
        put(c, s1); rd(hi_a[c]); check(q, s0[15:8]);
        rd(hi_a[c]); check(q, s1[15:8]);
        put(c, s2); rd(hi_a[c]); check(q, s2[15:8]);
        put(c, s0); rd(lo_a[c]); check(q, s2[7:0]);
        rd(lo_a[c]); check(q, s0[7:0]);
        put(c, s1); rd(lo_a[c]); check(q, s1[7:0]);
        put(c, s2); rd(hi_a[c]); check(q, s1[15:8]);
        rd(lo_a[c]); put(c, s0); wr(als_regs_pkg::ADDR_FLOOR_WR, s1);
        rd(hi_a[c]); check(q, s0[15:8]);
        $display("pair test %0d done", c);
    endtask : pair
    task automatic end_sim();
        $display("checked=%0d mismatches=%0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : end_sim
    // some 44 commands of three cycles each fit well inside this span
    initial begin
        #200000;
        mismatches++;
        end_sim();
    end
    initial begin
        logic [15:0] v, h;
        bx = 10'(rnd()); by = 10'(rnd()); wx = 10'(rnd()); wy = 10'(rnd());
        repeat (16) @(posedge clock);
        rstn <= 1'b1;
        repeat (2) @(posedge clock);
        rd(als_regs_pkg::ADDR_FLOOR_RD); check(q, 8'h00);
        rd(als_regs_pkg::ADDR_COEFF_RD_HI); check(q, 8'h80);
        rd(als_regs_pkg::ADDR_COEFF_RD_LO); check(q, 8'h00);
        rd(16'h6000); check(q, 8'h00);
        for (int i = 0; i < 3; i++) begin
            v = (i == 0) ? 16'h0000 : (i == 1) ? 16'h00ff : rnd();
            h = rnd();
            wr(als_regs_pkg::ADDR_FLOOR_WR, {h[7:0], v[7:0]}); check(floor, v[7:0]);
            rd(als_regs_pkg::ADDR_FLOOR_RD); check(q, v[7:0]);
        end
        // the end host alone programs the coefficient, high byte first
        wr(als_regs_pkg::ADDR_COEFF_WR_HI, h); wr(als_regs_pkg::ADDR_COEFF_WR_LO, v);
        check(coeff, {h[7:0], v[7:0]});
        rd(als_regs_pkg::ADDR_COEFF_RD_LO); check(q, v[7:0]);
        rd(als_regs_pkg::ADDR_COEFF_RD_HI); check(q, h[7:0]);
        $display("register test done");
        pair(0);
        pair(1);
        rd(als_regs_pkg::ADDR_BLACK_X); check(q, bx[9:2]);
        rd(als_regs_pkg::ADDR_BW_LOW); check(q, {bx[1:0], by[1:0], wx[1:0], wy[1:0]});
        sense_enable <= 1'b0;
        repeat (4) @(posedge clock);
        for (int i = 0; i < 4; i++) begin
            rd(i < 2 ? hi_a[i] : lo_a[i - 2]); check(q, 8'h00);
        end
        sense_enable <= 1'b1;
        rom_programmed <= 1'b0;
        soft_reset <= 1'b1;
        @(posedge clock);
        soft_reset <= 1'b0;
        repeat (2) @(posedge clock);
        check(coeff, 16'h8000);
        check(floor, 8'h00);
        rd(als_regs_pkg::ADDR_BLACK_X); check(q, 8'h00);
        rom_programmed <= 1'b1;
        rstn <= 1'b0;
        repeat (2) @(posedge clock);
        rstn <= 1'b1;
        repeat (2) @(posedge clock);
        check(coeff, 16'h8000);
        rd(als_regs_pkg::ADDR_BLACK_X); check(q, bx[9:2]);
        $display("reset test done");
        end_sim();
    end
endmodule : als_param_regs_tb
`default_nettype wire
